// file: src/mccf_defs.vh
// Constants for the monitor console control block
`ifndef MCCF_DEFS_VH
`define MCCF_DEFS_VH
// ==========================================
// Register offsets (byte addresses)
`define MCCF_OFS_CFG 8'h00
`define MCCF_OFS_STAT 8'h04
// ==========================================
// Configuration field positions
`define MCCF_CFG_MONO_LO 0
`define MCCF_CFG_MONO_HI 3
`define MCCF_CFG_DUAL 4
`define MCCF_CFG_MONO_LATCH 5
`define MCCF_CFG_AUTO_DIM 6
`define MCCF_CFG_TALK_LATCH 7
`define MCCF_CFG_SLATE_LATCH 8
`define MCCF_CFG_SLATE_HP 9
`define MCCF_CFG_TALK_ADD 10
`define MCCF_CFG_DIM_LO 11
`define MCCF_CFG_DIM_HI 13
// ==========================================
// Status field positions
`define MCCF_ST_CR_LO 0
`define MCCF_ST_HP_LO 4
`define MCCF_ST_DUB_LO 8
`define MCCF_ST_DIM 12
`define MCCF_ST_MONO 13
`define MCCF_ST_MODE_LO 14
`define MCCF_ST_TALK 17
`define MCCF_ST_SLATE 18
`define MCCF_ST_TLVL_LO 19
`define MCCF_ST_SLVL_LO 22
// ==========================================
// Reset values and level limits
`define MCCF_CFG_RST 32'h0000_0840
`define MCCF_SEL_RST 4'h1
`define MCCF_LVL_RST 3'h4
`define MCCF_LVL_MAX 3'h7
`define MCCF_LVL_MIN 3'h0
// ==========================================
// Dim amounts in dB
`define MCCF_DIM_DB0 5'h19
`define MCCF_DIM_DB1 5'h14
`define MCCF_DIM_DB2 5'h0f
// ==========================================
// Timing
`define MCCF_CLK_HZ 25000000
`define MCCF_HOLD_MS 2000
`define MCCF_DEB_MS 5
`define MCCF_BLINK_MS 250
`define MCCF_FLASH_TICKS 2'h2
`endif

// file: src/mccf_top.v
// Monitor console front-panel control logic with APB configuration
// Notes on behaviour
// - Select button sets control room and meter source
// - Mono-configured selected inputs blink their indicator
// - Dual mode: held plus pressed selects both
// - Phones held plus select sets headphone source
// - Phones held plus both levels deselects headphones
// - Dub held plus select or both levels
// - Dim latches; attenuation equals configured amount
// - Auto-dim-off: knob change while dim clears dim
// - Communications-forced dim ignores auto-dim-off
// - Mono sums L+R, momentary or latching
// - Two-second double-level hold cycles stereo/left/right
// - Left-only flashes mono once, right-only twice
// - Mono disabled and cancelled in single channel
// - Talk/slate enable microphone and light indicator
// - Only one communications function active
// - Each communications button latching or momentary
// - Slate feeds dub, and phones if configured
// - Slate-to-phones lights both, uses slate level
// - Talk interrupts or adds to headphone source
// - Own eight-step level per communications function
// - Indicator flashes per step, not at limits
// - Talk or slate engages dim automatically
// - Dim amount one-hot: 25, 20, 15 dB
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "mccf_defs.vh"

module mccf_top #(
  parameter HOLD_CYC  = `MCCF_CLK_HZ / 1000 * `MCCF_HOLD_MS,
  parameter DEB_CYC   = `MCCF_CLK_HZ / 1000 * `MCCF_DEB_MS,
  parameter BLINK_CYC = `MCCF_CLK_HZ / 1000 * `MCCF_BLINK_MS
) (
  input  wire        clock,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [3:0]  btn_sel,
  input  wire        btn_phones,
  input  wire        btn_dub,
  input  wire        btn_dim,
  input  wire        btn_mono,
  input  wire        btn_talk,
  input  wire        btn_slate,
  input  wire        btn_up,
  input  wire        btn_down,
  input  wire [7:0]  knob_level,
  output reg  [3:0]  monitor_source_select,
  output reg  [3:0]  meter_sel,
  output reg  [3:0]  hp_sel,
  output reg  [3:0]  dub_sel,
  output reg  [3:0]  cr_led,
  output reg  [3:0]  hp_led,
  output reg  [3:0]  dub_led,
  output reg  [4:0]  dim_db,
  output reg         dim_led,
  output reg         mono_out,
  output reg         mono_led,
  output reg         left_only,
  output reg         right_only,
  output reg         mic_en,
  output reg         mic_to_hp,
  output reg         mic_to_dub,
  output reg         hp_src_cut,
  output reg  [2:0]  hp_comm_lvl,
  output reg  [2:0]  dub_comm_lvl,
  output reg         talk_led,
  output reg         slate_led
);

  localparam MODE_ST = 3'b001;
  localparam MODE_L  = 3'b010;
  localparam MODE_R  = 3'b100;

  // ==========================================
  // Pin synchronisers and debounce
  wire [11:0] raw = {btn_down, btn_up, btn_slate, btn_talk, btn_mono, btn_dim,
                     btn_dub, btn_phones, btn_sel};
  reg  [11:0] s1_reg;
  reg  [11:0] s2_reg;
  reg  [11:0] smp_reg;
  reg  [11:0] deb_reg;
  reg  [11:0] debp_reg;
  reg  [7:0]  k1_reg;
  reg  [7:0]  k2_reg;
  reg  [7:0]  kp_reg;
  reg  [31:0] deb_cnt_reg;
  wire        deb_tick = (deb_cnt_reg == DEB_CYC - 1);
  // A level is taken only after two equal samples a tick apart
  wire [11:0] same = smp_reg ~^ s2_reg;

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_reg      <= 12'h000;
      s2_reg      <= 12'h000;
      smp_reg     <= 12'h000;
      deb_reg     <= 12'h000;
      debp_reg    <= 12'h000;
      k1_reg      <= 8'h00;
      k2_reg      <= 8'h00;
      kp_reg      <= 8'h00;
      deb_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      s1_reg   <= raw;
      s2_reg   <= s1_reg;
      k1_reg   <= knob_level;
      k2_reg   <= k1_reg;
      kp_reg   <= k2_reg;
      debp_reg <= deb_reg;
      deb_cnt_reg <= deb_tick ? 32'h0000_0000 : deb_cnt_reg + 32'h0000_0001;
      if (deb_tick)
      begin
        smp_reg <= s2_reg;
        deb_reg <= (deb_reg & ~same) | (s2_reg & same);
      end
    end
  end

  wire [11:0] rise    = deb_reg & ~debp_reg;
  wire [3:0]  d_sel   = deb_reg[3:0];
  wire [3:0]  r_sel   = rise[3:0];
  wire        d_ph    = deb_reg[4];
  wire        d_dub   = deb_reg[5];
  wire        r_dim   = rise[6];
  wire        d_mono  = deb_reg[7];
  wire        r_mono  = rise[7];
  wire        d_talk  = deb_reg[8];
  wire        r_talk  = rise[8];
  wire        d_slate = deb_reg[9];
  wire        r_slate = rise[9];
  wire        d_up    = deb_reg[10];
  wire        d_dn    = deb_reg[11];
  wire        r_up    = rise[10];
  wire        r_dn    = rise[11];
  wire        both_r  = d_up & d_dn & (r_up | r_dn);
  wire        knob_chg = (k2_reg != kp_reg);

  // ==========================================
  // Configuration register
  reg  [31:0] cfg_reg;
  wire [3:0]  cfg_mono  = cfg_reg[`MCCF_CFG_MONO_HI:`MCCF_CFG_MONO_LO];
  wire [2:0]  cfg_dim   = cfg_reg[`MCCF_CFG_DIM_HI:`MCCF_CFG_DIM_LO];
  wire        c_dual    = cfg_reg[`MCCF_CFG_DUAL];
  wire        c_mlatch  = cfg_reg[`MCCF_CFG_MONO_LATCH];
  wire        c_autodim = cfg_reg[`MCCF_CFG_AUTO_DIM];
  wire        c_tlatch  = cfg_reg[`MCCF_CFG_TALK_LATCH];
  wire        c_slatch  = cfg_reg[`MCCF_CFG_SLATE_LATCH];
  wire        c_s2hp    = cfg_reg[`MCCF_CFG_SLATE_HP];
  wire        c_tadd    = cfg_reg[`MCCF_CFG_TALK_ADD];

  // ==========================================
  // Shared blink timebase
  reg  [31:0] blk_cnt_reg;
  reg  [2:0]  phase_reg;
  wire        blk_tick = (blk_cnt_reg == BLINK_CYC - 1);

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      blk_cnt_reg <= 32'h0000_0000;
      phase_reg   <= 3'h0;
    end
    else
    begin
      blk_cnt_reg <= blk_tick ? 32'h0000_0000 : blk_cnt_reg + 32'h0000_0001;
      if (blk_tick)
        phase_reg <= phase_reg + 3'h1;
    end
  end

  wire blink_on = ~phase_reg[0];

  // ==========================================
  // Source selection
  reg  [3:0] cr_reg;
  reg  [3:0] hp_reg;
  reg  [3:0] dub_reg;
  reg  [3:0] cr_next;
  reg  [3:0] hp_next;
  reg  [3:0] dub_next;
  wire [3:0] new_one = r_sel & (~r_sel + 4'h1);
  wire [3:0] held    = d_sel & ~r_sel;
  wire [3:0] held1   = held & (~held + 4'h1);

  always @*
  begin
    cr_next  = cr_reg;
    hp_next  = hp_reg;
    dub_next = dub_reg;
    if (|r_sel)
    begin
      if (d_ph)
        hp_next = new_one;
      else if (d_dub)
        dub_next = new_one;
      else if (c_dual && (|held1))
        cr_next = held1 | new_one;
      else
        cr_next = new_one;
    end
    else if (both_r && d_ph)
      hp_next = 4'h0;
    else if (both_r && d_dub)
      dub_next = 4'h0;
  end

  // ==========================================
  // Left/right diagnostic mode
  reg [2:0]  mode_reg;
  reg [2:0]  mode_next;
  reg [31:0] hold_cnt_reg;
  reg        hold_done_reg;
  wire       hold_act = d_up & d_dn & ~d_ph & ~d_dub;
  wire       hold_hit = hold_act & ~hold_done_reg & (hold_cnt_reg == HOLD_CYC - 1);

  always @*
  begin
    mode_next = mode_reg;
    if (hold_hit)
    begin
      case (mode_reg)
        MODE_ST: mode_next = MODE_L;
        MODE_L:  mode_next = MODE_R;
        MODE_R:  mode_next = MODE_ST;
        default: mode_next = MODE_ST;
      endcase
    end
  end

  // ==========================================
  // Communications functions
  reg  talk_reg;
  reg  slate_reg;
  reg  talk_next;
  reg  slate_next;

  always @*
  begin
    talk_next  = c_tlatch ? (talk_reg ^ r_talk) : d_talk;
    slate_next = c_slatch ? (slate_reg ^ r_slate) : d_slate;
    if (talk_next && slate_next)
    begin
      // Slate wins on the cycle of its press, talk wins otherwise
      if (r_slate)
        talk_next = 1'b0;
      else
        slate_next = 1'b0;
    end
  end

  wire comm = talk_reg | slate_reg;

  // ==========================================
  // Levels, dim and mono
  reg  [2:0] tlvl_reg;
  reg  [2:0] slvl_reg;
  reg  [1:0] flash_reg;
  reg        dim_reg;
  reg        mono_reg;
  wire       step_ok = comm & ~d_ph & ~d_dub;
  wire       up_req  = step_ok & r_up & ~d_dn;
  wire       dn_req  = step_ok & r_dn & ~d_up;
  wire [2:0] cur_lvl = slate_reg ? slvl_reg : tlvl_reg;
  wire       can_up  = up_req & (cur_lvl != `MCCF_LVL_MAX);
  wire       can_dn  = dn_req & (cur_lvl != `MCCF_LVL_MIN);
  wire [2:0] stepped = can_up ? cur_lvl + 3'h1 : cur_lvl - 3'h1;
  wire       stereo  = (mode_next == MODE_ST);

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cr_reg        <= `MCCF_SEL_RST;
      hp_reg        <= `MCCF_SEL_RST;
      dub_reg       <= `MCCF_SEL_RST;
      mode_reg      <= MODE_ST;
      hold_cnt_reg  <= 32'h0000_0000;
      hold_done_reg <= 1'b0;
      talk_reg      <= 1'b0;
      slate_reg     <= 1'b0;
      tlvl_reg      <= `MCCF_LVL_RST;
      slvl_reg      <= `MCCF_LVL_RST;
      flash_reg     <= 2'h0;
      dim_reg       <= 1'b0;
      mono_reg      <= 1'b0;
    end
    else
    begin
      cr_reg    <= cr_next;
      hp_reg    <= hp_next;
      dub_reg   <= dub_next;
      mode_reg  <= mode_next;
      talk_reg  <= talk_next;
      slate_reg <= slate_next;
      // Counter stays put once fired so one hold gives one step
      if (!hold_act)
      begin
        hold_cnt_reg  <= 32'h0000_0000;
        hold_done_reg <= 1'b0;
      end
      else if (hold_hit)
        hold_done_reg <= 1'b1;
      else if (!hold_done_reg)
        hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
      if (can_up || can_dn)
      begin
        if (slate_reg)
          slvl_reg <= stepped;
        else
          tlvl_reg <= stepped;
        flash_reg <= `MCCF_FLASH_TICKS;
      end
      else if (blk_tick && (flash_reg != 2'h0))
        flash_reg <= flash_reg - 2'h1;
      // Auto-dim-off clears only the button latch, never comm dim
      if (r_dim)
        dim_reg <= ~dim_reg;
      else if (c_autodim && dim_reg && knob_chg)
        dim_reg <= 1'b0;
      if (!stereo)
        mono_reg <= 1'b0;
      else if (c_mlatch)
        mono_reg <= mono_reg ^ r_mono;
      else
        mono_reg <= d_mono;
    end
  end

  // ==========================================
  // Registered outputs
  wire       dim_eff  = dim_reg | comm;
  wire [3:0] blank    = cfg_mono & {4{~blink_on}};
  wire       flash_once  = (phase_reg == 3'h0);
  wire       flash_twice = (phase_reg == 3'h0) | (phase_reg == 3'h2);
  reg  [4:0] dim_amt;

  always @*
  begin
    case (cfg_dim)
      3'b001:  dim_amt = `MCCF_DIM_DB0;
      3'b010:  dim_amt = `MCCF_DIM_DB1;
      3'b100:  dim_amt = `MCCF_DIM_DB2;
      default: dim_amt = `MCCF_DIM_DB0;
    endcase
  end

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      monitor_source_select <= 4'h0;
      meter_sel    <= 4'h0;
      hp_sel       <= 4'h0;
      dub_sel      <= 4'h0;
      cr_led       <= 4'h0;
      hp_led       <= 4'h0;
      dub_led      <= 4'h0;
      dim_db       <= 5'h00;
      dim_led      <= 1'b0;
      mono_out     <= 1'b0;
      mono_led     <= 1'b0;
      left_only    <= 1'b0;
      right_only   <= 1'b0;
      mic_en       <= 1'b0;
      mic_to_hp    <= 1'b0;
      mic_to_dub   <= 1'b0;
      hp_src_cut   <= 1'b0;
      hp_comm_lvl  <= 3'h0;
      dub_comm_lvl <= 3'h0;
      talk_led     <= 1'b0;
      slate_led    <= 1'b0;
    end
    else
    begin
      monitor_source_select <= cr_reg;
      meter_sel    <= cr_reg;
      hp_sel       <= hp_reg;
      dub_sel      <= dub_reg;
      cr_led       <= cr_reg & ~blank;
      hp_led       <= hp_reg & ~blank;
      dub_led      <= dub_reg & ~blank;
      dim_db       <= dim_eff ? dim_amt : 5'h00;
      dim_led      <= dim_eff;
      mono_out     <= mono_reg;
      left_only    <= (mode_reg == MODE_L);
      right_only   <= (mode_reg == MODE_R);
      case (mode_reg)
        MODE_L:  mono_led <= flash_once;
        MODE_R:  mono_led <= flash_twice;
        default: mono_led <= mono_reg;
      endcase
      mic_en       <= comm;
      mic_to_hp    <= talk_reg | (slate_reg & c_s2hp);
      mic_to_dub   <= slate_reg;
      hp_src_cut   <= talk_reg & ~c_tadd;
      hp_comm_lvl  <= slate_reg ? slvl_reg : tlvl_reg;
      dub_comm_lvl <= slvl_reg;
      talk_led     <= (talk_reg | (slate_reg & c_s2hp)) & (flash_reg == 2'h0);
      slate_led    <= slate_reg & (flash_reg == 2'h0);
    end
  end

  // ==========================================
  // APB slave, zero wait states
  wire [31:0] status = {7'h00, slvl_reg, tlvl_reg, slate_reg, talk_reg, mode_reg,
                        mono_reg, dim_reg, dub_reg, hp_reg, cr_reg};
  wire        hit_cfg  = (paddr == `MCCF_OFS_CFG);
  wire        hit_stat = (paddr == `MCCF_OFS_STAT);
  wire        setup    = psel & ~penable;
  wire        wr_go    = psel & penable & pready & pwrite & hit_cfg;
  wire [2:0]  wr_dim   = pwdata[`MCCF_CFG_DIM_HI:`MCCF_CFG_DIM_LO];
  wire        dim_ok   = (wr_dim == 3'b001) | (wr_dim == 3'b010) | (wr_dim == 3'b100);

  always @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_reg <= `MCCF_CFG_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit_cfg & ~(hit_stat & ~pwrite);
      if (setup)
        prdata <= hit_cfg ? cfg_reg : (hit_stat ? status : 32'h0000_0000);
      if (wr_go)
      begin
        // Bad dim codes keep the old one-hot choice
        cfg_reg[10:0] <= pwdata[10:0];
        if (dim_ok)
          cfg_reg[`MCCF_CFG_DIM_HI:`MCCF_CFG_DIM_LO] <= wr_dim;
      end
    end
  end

endmodule
`default_nettype wire

// file: dv/mccf_checker_assertions.sv
// Port-level checker for the monitor console control block
`timescale 1ns/10ps
`default_nettype none
module mccf_checker (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [3:0] monitor_source_select,
  input wire logic [3:0] meter_sel,
  input wire logic [3:0] hp_sel,
  input wire logic [3:0] cr_led,
  input wire logic [3:0] hp_led,
  input wire logic [4:0] dim_db,
  input wire logic       dim_led,
  input wire logic       mono_out,
  input wire logic       left_only,
  input wire logic       right_only,
  input wire logic       mic_en,
  input wire logic       mic_to_dub,
  input wire logic       hp_src_cut
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ==========================================
  // Properties
  bad_addr_a: assert property (psel && !penable && paddr != 8'h00 && paddr != 8'h04
    |=> pready && pslverr) else $error("unmapped access not refused");
  meter_copy_a: assert property (meter_sel == monitor_source_select)
    else $error("meter source differs");
  led_blank_a: assert property (((cr_led & ~monitor_source_select) | (hp_led & ~hp_sel)) == 4'h0)
    else $error("unselected indicator lit");
  hp_pick_a: assert property ($onehot0(hp_sel))
    else $error("headphone source not single");
  dim_amount_a: assert property (dim_db != 5'h00 |->
    dim_db == 5'h19 || dim_db == 5'h14 || dim_db == 5'h0f) else $error("bad dim amount");
  mode_order_a: assert property ($rose(right_only) |-> $past(left_only))
    else $error("right-only not after left-only");
  mono_cancel_a: assert property (left_only || right_only |-> !mono_out)
    else $error("mono in single channel");
  mic_route_a: assert property (mic_to_dub || hp_src_cut |-> mic_en)
    else $error("mic routed while off");
  comm_one_a: assert property (hp_src_cut |-> !mic_to_dub)
    else $error("talk and slate together");
  comm_dim_a: assert property ($rose(mic_en) |-> ##[0:2] dim_led && dim_db != 5'h00)
    else $error("comm without dim");
endmodule
bind mccf_top mccf_checker chk_i (.clock, .resetn, .psel, .penable, .paddr, .pready,
  .pslverr, .monitor_source_select, .meter_sel, .hp_sel, .cr_led, .hp_led, .dim_db,
  .dim_led, .mono_out, .left_only, .right_only, .mic_en, .mic_to_dub, .hp_src_cut);
`default_nettype wire

// file: dv/mccf_operator.sv
// Behavioural operator at the console front panel
`timescale 1ns/10ps
`default_nettype none
module mccf_operator (
  input  wire logic        clock,
  output var  logic [11:0] btn,
  output var  logic [7:0]  knob_level
);
  initial
  begin
    btn = 12'h000;
    knob_level = 8'h80;
  end
  // Contacts chatter for two cycles; the debouncer has to absorb it
  task automatic set_btn(input logic [11:0] m, input logic v);
    begin
      @(posedge clock);
      btn <= btn ^ m;
      @(posedge clock);
      btn <= btn ^ m;
      @(posedge clock);
      btn <= v ? (btn | m) : (btn & ~m);
    end
  endtask
  task automatic turn;
    begin
      @(posedge clock);
      knob_level <= knob_level + 8'h10;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/test_monitor_console_control_fsm.sv
// Self-checking bench for the monitor console control block
`timescale 1ns/10ps
`default_nettype none
module test_monitor_console_control_fsm;
  // ==========================================
  // Signals
  localparam logic [11:0] PH  = 12'h010;
  localparam logic [11:0] DUB = 12'h020;
  localparam logic [11:0] DIM = 12'h040;
  localparam logic [11:0] MO  = 12'h080;
  localparam logic [11:0] TK  = 12'h100;
  localparam logic [11:0] SL  = 12'h200;
  localparam logic [11:0] UP  = 12'h400;
  localparam logic [11:0] LV  = 12'hc00;
  logic [4:0]  dim_tab [3] = '{5'h19, 5'h14, 5'h0f};
  logic [1:0]  mode_tab [3] = '{2'b10, 2'b01, 2'b00};
  logic        clock;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] rdata;
  logic        rerr;
  int          n_mismatch;
  int          total_checks;
  wire  [31:0] prdata;
  wire  [11:0] btn;
  wire  [7:0]  knob_level;
  wire  [4:0]  dim_db;
  wire  [2:0]  hp_comm_lvl;
  wire  [3:0]  monitor_source_select, meter_sel, hp_sel, dub_sel, cr_led, hp_led;
  wire         pready, pslverr, mono_out, left_only, right_only, mic_en, mic_to_dub, hp_src_cut;
  wire         mono_led, talk_led, slate_led;
  // Short counts keep the run brief
  mccf_top #(.HOLD_CYC(200), .DEB_CYC(4), .BLINK_CYC(8)) uut (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .btn_sel(btn[3:0]), .btn_phones(btn[4]), .btn_dub(btn[5]), .btn_dim(btn[6]),
    .btn_mono(btn[7]), .btn_talk(btn[8]), .btn_slate(btn[9]), .btn_up(btn[10]),
    .btn_down(btn[11]), .knob_level, .monitor_source_select, .meter_sel, .hp_sel, .dub_sel,
    .cr_led, .hp_led, .dub_led(), .dim_db, .dim_led(), .mono_out, .mono_led, .left_only,
    .right_only, .mic_en, .mic_to_hp(), .mic_to_dub, .hp_src_cut, .hp_comm_lvl,
    .dub_comm_lvl(), .talk_led, .slate_led);
  mccf_operator op (.clock, .btn, .knob_level);
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      total_checks++;
      if (g !== e)
      begin
        n_mismatch++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do
        @(posedge clock);
      while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Debounce plus sync needs about a dozen cycles; thirty leaves margin
  task automatic settle;
    repeat (30) @(posedge clock);
  endtask
  task automatic hold(input logic [11:0] m, input logic v);
    begin
      op.set_btn(m, v);
      settle;
    end
  endtask
  task automatic tap(input logic [11:0] m);
    begin
      hold(m, 1'b1);
      hold(m, 1'b0);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    begin
      chk("source", 32'h1, 32'(monitor_source_select));
      chk("dim", 32'h0, 32'(dim_db));
      apb(1'b0, 8'h00, 32'h0);
      chk("cfg", 32'h0000_0840, rdata);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, 32'(rerr));
    end
  endtask
  task automatic t_select;
    for (int i = 3; i >= 0; i--)
    begin
      tap(12'h001 << i);
      chk("source", 32'h1 << i, 32'(monitor_source_select));
      chk("meter", 32'h1 << i, 32'(meter_sel));
      chk("cr led", 32'h1 << i, 32'(cr_led));
    end
  endtask
  task automatic t_route;
    begin
      for (int k = 0; k < 2; k++)
      begin
        hold(k ? DUB : PH, 1'b1);
        tap(12'h004);
        chk("assign", 32'h4, 32'(k ? dub_sel : hp_sel));
        tap(LV);
        chk("assign", 32'h0, 32'(k ? dub_sel : hp_sel));
        hold(k ? DUB : PH, 1'b0);
      end
      chk("hp led", 32'h0, 32'(hp_led));
    end
  endtask
  task automatic t_dual;
    begin
      apb(1'b1, 8'h00, 32'h0000_0850);
      hold(12'h001, 1'b1);
      tap(12'h008);
      hold(12'h001, 1'b0);
      chk("dual", 32'h9, 32'(monitor_source_select));
    end
  endtask
  task automatic t_dim;
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, 8'h00, 32'h0000_0040 | (32'h0000_0800 << j));
      tap(DIM);
      chk("dim", 32'(dim_tab[j]), 32'(dim_db));
      if (j == 2)
        op.turn;
      else
        tap(DIM);
      settle;
      chk("dim", 32'h0, 32'(dim_db));
    end
  endtask
  task automatic t_mono;
    int ones;
    begin
      apb(1'b1, 8'h00, 32'h0000_0840);
      hold(MO, 1'b1);
      chk("mono", 32'h1, 32'(mono_out));
      hold(MO, 1'b0);
      chk("mono", 32'h0, 32'(mono_out));
      apb(1'b1, 8'h00, 32'h0000_0860);
      tap(MO);
      chk("mono", 32'h1, 32'(mono_out));
      for (int i = 0; i < 3; i++)
      begin
        hold(LV, 1'b1);
        repeat (300) @(posedge clock);
        hold(LV, 1'b0);
        chk("mode", 32'(mode_tab[i]), 32'({left_only, right_only}));
        ones = 0;
        repeat (64)
        begin
          @(posedge clock);
          ones += mono_led;
        end
        chk("mono led", 32'(i == 0 ? 8 : (i == 1 ? 16 : 0)), 32'(ones));
        tap(MO);
        chk("mono", 32'(i == 2), 32'(mono_out));
      end
    end
  endtask
  task automatic t_talk;
    begin
      apb(1'b1, 8'h00, 32'h0000_0840);
      hold(TK, 1'b1);
      chk("mic", 32'h1, 32'(mic_en));
      hold(TK, 1'b0);
      chk("mic", 32'h0, 32'(mic_en));
      apb(1'b1, 8'h00, 32'h0000_09c0);
      tap(TK);
      chk("cut", 32'h1, 32'(hp_src_cut));
      op.turn;
      settle;
      chk("dim", 32'h19, 32'(dim_db));
      repeat (4) tap(UP);
      chk("level", 32'h7, 32'(hp_comm_lvl));
      chk("talk led", 32'h1, 32'(talk_led));
      tap(SL);
      chk("slate led", 32'h1, 32'(slate_led));
      chk("talk led", 32'h0, 32'(talk_led));
      chk("level", 32'h4, 32'(hp_comm_lvl));
      apb(1'b0, 8'h04, 32'h0);
      chk("comm", 32'h2, 32'(rdata[18:17]));
      chk("dub mic", 32'h1, 32'(mic_to_dub));
      tap(SL);
      chk("mic", 32'h0, 32'(mic_en));
    end
  endtask
  task automatic t_blink;
    int ones;
    begin
      ones = 0;
      apb(1'b1, 8'h00, 32'h0000_0841);
      tap(12'h001);
      repeat (128)
      begin
        @(posedge clock);
        ones += cr_led[0];
      end
      chk("blink", 32'h1, 32'(ones > 0 && ones < 128));
      chk("source", 32'h1, 32'(monitor_source_select));
    end
  endtask
  task automatic summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // ==========================================
  // Run
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset;
    t_select;
    t_route;
    t_dual;
    t_dim;
    t_mono;
    t_talk;
    t_blink;
    summarize;
  end
  // Whole sequence needs well under ten thousand cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    summarize;
  end
endmodule
`default_nettype wire
